/* dram_host_pkg.sv */
// Package for the page-mode DRAM host controller: geometry, timing and states.
// Assumes a 100 MHz core clock; the delay, pause and refresh counts are derived from times in ns, us and ms.
package dram_host_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ROW_W = 9;
  localparam int COL_W = 9;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  // Minimum strobe and delay times in ns, rounded up to cycles below.
  localparam int ROW_ACTIVE_NS = 60;
  localparam int ROW_PRECHARGE_NS = 40;
  localparam int COL_PULSE_NS = 15;
  localparam int OUT_OFF_DATA_NS = 10;
  localparam int ACCESS_NS = 60;
  localparam int ROW_ACTIVE_CYC = (ROW_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_PRECHARGE_CYC = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COL_PULSE_CYC = (COL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OUT_OFF_DATA_CYC = (OUT_OFF_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Power-up pause and refresh budget.
  localparam int POWER_UP_US = 200;
  localparam int POWER_UP_CYC = POWER_UP_US * 1000 / CLK_PERIOD_NS;
  localparam int REFRESH_MS = 8;
  localparam int REFRESH_CYCLES = 256;
  localparam int REFRESH_CYC = REFRESH_MS * 1000000 / CLK_PERIOD_NS / REFRESH_CYCLES;
  localparam int INIT_CYCLES = 8;
  localparam int TIMER_W = 16;
  localparam int STEP_W = 4;
  typedef enum logic [7:0] {
    ST_POWER = 8'h01,
    ST_IDLE = 8'h02,
    ST_ROW = 8'h04,
    ST_COL = 8'h08,
    ST_HOLD = 8'h10,
    ST_PRECH = 8'h20,
    ST_CBR_COL = 8'h40,
    ST_CBR_ROW = 8'h80
  } state_e;
endpackage

/* dram_host_ctrl.sv */
// Host controller that drives an asynchronous page-mode DRAM through its pins.
// Assumes the DRAM shares the board with this clock; data pins are resynchronised.
`timescale 1ns/1ps
module dram_host_ctrl #(
  parameter int POWER_UP_COUNT = dram_host_pkg::POWER_UP_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [dram_host_pkg::ROW_W-1:0] req_row_in,
  input wire logic [dram_host_pkg::COL_W-1:0] req_col_in,
  input wire logic [1:0] req_byte_en_in,
  input wire logic [dram_host_pkg::DATA_W-1:0] req_wdata_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [dram_host_pkg::DATA_W-1:0] rd_data_out,
  output logic init_done_out,
  output logic row_strobe_n_out,
  output logic upper_byte_strobe_n_out,
  output logic lower_byte_strobe_n_out,
  output logic write_enable_n_out,
  output logic output_enable_n_out,
  output logic [dram_host_pkg::ADDR_W-1:0] address_inputs_out,
  input wire logic [dram_host_pkg::DATA_W-1:0] data_in,
  output logic [dram_host_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out
);
  dram_host_pkg::state_e state, next_state;
  logic [dram_host_pkg::TIMER_W-1:0] wait_cnt;
  logic [dram_host_pkg::TIMER_W-1:0] power_cnt;
  logic [dram_host_pkg::TIMER_W-1:0] refresh_cnt;
  logic [dram_host_pkg::STEP_W-1:0] init_cnt;
  logic [dram_host_pkg::ROW_W-1:0] open_row;
  logic row_open;
  logic refresh_pending;
  logic cur_write;
  logic [1:0] cur_be;
  logic [dram_host_pkg::COL_W-1:0] cur_col;
  logic [dram_host_pkg::DATA_W-1:0] data_meta, data_sync;

  // Data pins come from outside the clock domain and pass two flops.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_meta <= '0;
      data_sync <= '0;
    end else begin
      data_meta <= data_in;
      data_sync <= data_meta;
    end
  end

  // Decoding of the request against the open page and the timers.
  wire power_done = (power_cnt == '0);
  wire wait_done = (wait_cnt == '0);
  wire init_done = (init_cnt == dram_host_pkg::STEP_W'(dram_host_pkg::INIT_CYCLES));
  wire page_hit = row_open && (open_row == req_row_in);
  wire take_req = (state == dram_host_pkg::ST_IDLE || state == dram_host_pkg::ST_HOLD)
                  && req_valid_in && !refresh_pending && init_done;
  wire refresh_due = (refresh_cnt == '0);
  // A page hit is taken only once the row-active timer of the open page has run out.
  assign req_ready_out = take_req && (state == dram_host_pkg::ST_IDLE || (page_hit && wait_done));
  assign init_done_out = init_done;

  // Next-state logic; refresh wins over new accesses and closes an open page.
  always_comb begin
    next_state = state;
    case (state)
      dram_host_pkg::ST_POWER: begin
        if (power_done) next_state = dram_host_pkg::ST_CBR_COL;
      end
      dram_host_pkg::ST_IDLE: begin
        if (refresh_pending || !init_done) next_state = dram_host_pkg::ST_CBR_COL;
        else if (req_valid_in) next_state = dram_host_pkg::ST_ROW;
      end
      dram_host_pkg::ST_ROW: begin
        if (wait_done) next_state = dram_host_pkg::ST_COL;
      end
      dram_host_pkg::ST_COL: begin
        if (wait_done) next_state = dram_host_pkg::ST_HOLD;
      end
      dram_host_pkg::ST_HOLD: begin
        if (!wait_done) next_state = dram_host_pkg::ST_HOLD;
        else if (req_ready_out) next_state = dram_host_pkg::ST_ROW;
        else if (refresh_pending || req_valid_in) next_state = dram_host_pkg::ST_PRECH;
      end
      dram_host_pkg::ST_PRECH: begin
        if (wait_done) next_state = dram_host_pkg::ST_IDLE;
      end
      dram_host_pkg::ST_CBR_COL: begin
        if (wait_done) next_state = dram_host_pkg::ST_CBR_ROW;
      end
      dram_host_pkg::ST_CBR_ROW: begin
        if (wait_done) next_state = dram_host_pkg::ST_PRECH;
      end
      default: next_state = dram_host_pkg::ST_IDLE;
    endcase
  end

  // Delay loaded on each state entry.
  wire [dram_host_pkg::TIMER_W-1:0] entry_wait =
    (next_state == dram_host_pkg::ST_ROW) ? dram_host_pkg::TIMER_W'(dram_host_pkg::OUT_OFF_DATA_CYC) :
    (next_state == dram_host_pkg::ST_COL) ? dram_host_pkg::TIMER_W'(dram_host_pkg::ACCESS_CYC) :
    (next_state == dram_host_pkg::ST_HOLD) ? dram_host_pkg::TIMER_W'(dram_host_pkg::ROW_ACTIVE_CYC) :
    (next_state == dram_host_pkg::ST_PRECH) ? dram_host_pkg::TIMER_W'(dram_host_pkg::ROW_PRECHARGE_CYC) :
    (next_state == dram_host_pkg::ST_CBR_COL) ? dram_host_pkg::TIMER_W'(dram_host_pkg::COL_PULSE_CYC) :
    dram_host_pkg::TIMER_W'(dram_host_pkg::ROW_ACTIVE_CYC);

  // State register and wait counter.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= dram_host_pkg::ST_POWER;
      wait_cnt <= '0;
    end else begin
      state <= next_state;
      if (next_state != state || (state == dram_host_pkg::ST_HOLD && req_ready_out))
        wait_cnt <= entry_wait;
      else if (!wait_done)
        wait_cnt <= wait_cnt - 1'b1;
    end
  end

  // Power-up pause, init cycle count and refresh interval timer.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      power_cnt <= dram_host_pkg::TIMER_W'(POWER_UP_COUNT);
      init_cnt <= '0;
      refresh_cnt <= dram_host_pkg::TIMER_W'(dram_host_pkg::REFRESH_CYC - 1);
      refresh_pending <= 1'b0;
    end else begin
      if (!power_done) power_cnt <= power_cnt - 1'b1;
      if (state == dram_host_pkg::ST_CBR_ROW && next_state == dram_host_pkg::ST_PRECH && !init_done)
        init_cnt <= init_cnt + 1'b1;
      // Reload one short so that the period is exactly the refresh interval.
      refresh_cnt <= refresh_due ? dram_host_pkg::TIMER_W'(dram_host_pkg::REFRESH_CYC - 1)
                                 : refresh_cnt - 1'b1;
      if (refresh_due) refresh_pending <= 1'b1;
      else if (state == dram_host_pkg::ST_CBR_ROW) refresh_pending <= 1'b0;
    end
  end

  // Pin drivers; strobes high from reset so power-up starts no cycle.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      row_strobe_n_out <= 1'b1;
      upper_byte_strobe_n_out <= 1'b1;
      lower_byte_strobe_n_out <= 1'b1;
      write_enable_n_out <= 1'b1;
      output_enable_n_out <= 1'b1;
      address_inputs_out <= '0;
      data_out <= '0;
      data_oe_out <= 1'b0;
      open_row <= '0;
      row_open <= 1'b0;
      cur_write <= 1'b0;
      cur_be <= 2'h0;
      cur_col <= '0;
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
    end else begin
      rd_valid_out <= 1'b0;
      if (take_req && (next_state == dram_host_pkg::ST_ROW || next_state == dram_host_pkg::ST_COL)) begin
        cur_write <= req_write_in;
        cur_be <= req_byte_en_in;
        cur_col <= req_col_in;
        address_inputs_out <= (state == dram_host_pkg::ST_IDLE) ? req_row_in : req_col_in;
        open_row <= req_row_in;
        data_out <= req_wdata_in;
        data_oe_out <= req_write_in;
        // Early write: enable low before column strobe; reads keep it high.
        write_enable_n_out <= !req_write_in;
        output_enable_n_out <= 1'b1;
      end
      case (next_state)
        dram_host_pkg::ST_ROW: begin
          row_strobe_n_out <= 1'b0;
          row_open <= 1'b1;
          // Column address settles a cycle ahead of the byte strobes.
          if (state == dram_host_pkg::ST_ROW) address_inputs_out <= cur_col;
        end
        dram_host_pkg::ST_COL: begin
          // Every column access, first or in page, comes through the row step.
          if (state == dram_host_pkg::ST_ROW) begin
            upper_byte_strobe_n_out <= !cur_be[1];
            lower_byte_strobe_n_out <= !cur_be[0];
          end
          output_enable_n_out <= cur_write;
        end
        dram_host_pkg::ST_HOLD: begin
          if (state == dram_host_pkg::ST_COL) begin
            upper_byte_strobe_n_out <= 1'b1;
            lower_byte_strobe_n_out <= 1'b1;
            output_enable_n_out <= 1'b1;
            write_enable_n_out <= 1'b1;
            data_oe_out <= 1'b0;
            rd_valid_out <= !cur_write;
            rd_data_out <= data_sync;
          end
        end
        dram_host_pkg::ST_PRECH: begin
          row_strobe_n_out <= 1'b1;
          upper_byte_strobe_n_out <= 1'b1;
          lower_byte_strobe_n_out <= 1'b1;
          row_open <= 1'b0;
        end
        dram_host_pkg::ST_CBR_COL: begin
          // Refresh: no data, pins released, address ignored by the device.
          upper_byte_strobe_n_out <= 1'b0;
          lower_byte_strobe_n_out <= 1'b0;
          write_enable_n_out <= 1'b1;
          output_enable_n_out <= 1'b1;
          data_oe_out <= 1'b0;
        end
        dram_host_pkg::ST_CBR_ROW: row_strobe_n_out <= 1'b0;
        default: row_strobe_n_out <= row_strobe_n_out;
      endcase
    end
  end
endmodule // dram_host_ctrl

/* dram_host_ctrl_props.sv */
// Checker on the controller's pins: strobe timing, write order, refresh spacing.
// Assumes one clock domain; bound to every controller instance.
`timescale 1ns/1ps
module dram_host_ctrl_props #(
  parameter int POWER_UP_COUNT = 20
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic init_done_out,
  input wire logic row_strobe_n_out,
  input wire logic upper_byte_strobe_n_out,
  input wire logic lower_byte_strobe_n_out,
  input wire logic write_enable_n_out,
  input wire logic output_enable_n_out,
  input wire logic [dram_host_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe_out
);
  localparam int GAP_MAX = dram_host_pkg::REFRESH_CYC + 64;
  int up_cnt;
  int ras_cnt;
  int gap_cnt;
  // Aliases; col_n is low while either byte strobe is low.
  wire row_n = row_strobe_n_out;
  wire col_n = upper_byte_strobe_n_out & lower_byte_strobe_n_out;
  wire we_n = write_enable_n_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Counts the pause, the row cycles and the time since the last refresh.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      up_cnt <= 0;
      ras_cnt <= 0;
      gap_cnt <= 0;
    end else begin
      up_cnt <= (up_cnt < POWER_UP_COUNT) ? up_cnt + 1 : up_cnt;
      ras_cnt <= ras_cnt + int'($fell(row_n));
      gap_cnt <= (!init_done_out || ($fell(row_n) && !col_n)) ? 0 : gap_cnt + 1;
    end
  end
  AST_POWER_QUIET: assert property (up_cnt < POWER_UP_COUNT - 1 |-> row_n && col_n)
    else $error("strobe active in power-up pause");
  AST_INIT_ROWS: assert property ($rose(init_done_out) |-> ras_cnt >= 8)
    else $error("ready before eight row cycles");
  AST_ROW_ACTIVE: assert property ($fell(row_n) |-> !row_n [*6])
    else $error("row strobe low too short");
  AST_PRECHARGE: assert property ($rose(row_n) |-> row_n [*4])
    else $error("row precharge too short");
  AST_EARLY_WRITE: assert property ($fell(col_n) && !we_n |-> $past(we_n) == 1'b0)
    else $error("write enable not ahead of column strobe");
  AST_WRITE_DATA: assert property ($fell(col_n) && !we_n |->
    data_oe_out && output_enable_n_out && $stable(data_out))
    else $error("write data not ready at column strobe");
  AST_NO_CONTENTION: assert property (!output_enable_n_out |-> !data_oe_out && we_n)
    else $error("host drives pins while reading");
  AST_CBR_ORDER: assert property ($fell(row_n) && !col_n |-> $past(col_n) == 1'b0)
    else $error("column strobe not ahead of row strobe");
  AST_REFRESH_GAP: assert property (gap_cnt < GAP_MAX)
    else $error("refresh interval overrun");
  cover property ($rose(init_done_out));
  cover property ($fell(row_n) && !col_n);
  cover property ($fell(col_n) && !we_n);
endmodule // dram_host_ctrl_props
bind dram_host_ctrl dram_host_ctrl_props #(.POWER_UP_COUNT(POWER_UP_COUNT)) props_i (
  .core_clk_in, .rst_b_in, .init_done_out, .row_strobe_n_out, .upper_byte_strobe_n_out,
  .lower_byte_strobe_n_out, .write_enable_n_out, .output_enable_n_out, .data_out, .data_oe_out);

/* dram_model.sv */
// Pin-level model of the page-mode DRAM with a sparse cell array.
// Assumes the host's data and enable arrive here; resolved pins go back out.
`timescale 1ns/1ps
module dram_model (
  input wire logic row_strobe_n_in,
  input wire logic upper_byte_strobe_n_in,
  input wire logic lower_byte_strobe_n_in,
  input wire logic write_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic [8:0] address_in,
  input wire logic [15:0] host_data_in,
  input wire logic host_oe_in,
  output logic [15:0] pins_out,
  output int row_cycles_out = 0,
  output int refreshes_out = 0
);
  logic [15:0] cells [logic [17:0]];
  logic [8:0] row = 9'h000;
  logic [8:0] ref_row = 9'h000;
  logic [15:0] q = 16'h0000;
  logic [15:0] w;
  logic refreshing = 1'b0;
  logic hi_en;
  logic lo_en;
  // Row fall opens a row, or refreshes from the counter when a column strobe led.
  always @(negedge row_strobe_n_in) begin
    #1; // The host moves address and row strobe on one edge; let both settle.
    row_cycles_out = row_cycles_out + 1;
    refreshing = !(upper_byte_strobe_n_in && lower_byte_strobe_n_in);
    if (refreshing) begin
      refreshes_out = refreshes_out + 1;
      ref_row = ref_row + 9'h001;
    end else begin
      row = address_in;
    end
  end
  // Column fall latches the column; a write takes the host's lanes, a read fills the latch.
  always @(negedge upper_byte_strobe_n_in or negedge lower_byte_strobe_n_in) begin
    if (!row_strobe_n_in && !refreshing) begin
      w = cells.exists({row, address_in}) ? cells[{row, address_in}] : 16'h0000;
      if (!write_enable_n_in) begin
        if (!upper_byte_strobe_n_in) w[15:8] = host_oe_in ? host_data_in[15:8] : ~w[15:8];
        if (!lower_byte_strobe_n_in) w[7:0] = host_oe_in ? host_data_in[7:0] : ~w[7:0];
        cells[{row, address_in}] = w;
      end
      q = w; // Access is immediate once the column is latched.
    end
  end
  // A lane drives the latch only in a read with its strobe and output enable low.
  assign hi_en = !row_strobe_n_in && !upper_byte_strobe_n_in && !output_enable_n_in
    && write_enable_n_in && !refreshing;
  assign lo_en = !row_strobe_n_in && !lower_byte_strobe_n_in && !output_enable_n_in
    && write_enable_n_in && !refreshing;
  // Undriven lanes show the inverse of the latch, never a held value.
  assign pins_out[15:8] = host_oe_in ? host_data_in[15:8] : (hi_en ? q[15:8] : ~q[15:8]);
  assign pins_out[7:0] = host_oe_in ? host_data_in[7:0] : (lo_en ? q[7:0] : ~q[7:0]);
endmodule // dram_model

/* page_mode_dram_core_behaviour_test.sv */
// Self-checking bench for the DRAM host controller against the pin-level model.
// Assumes a 100 MHz clock and a shortened power-up pause.
`timescale 1ns/1ps
module page_mode_dram_core_behaviour_test;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic [8:0] req_row_in = 9'h000;
  logic [8:0] req_col_in = 9'h000;
  logic [1:0] req_byte_en_in = 2'h0;
  logic [15:0] req_wdata_in = 16'h0000;
  logic req_ready_out, rd_valid_out, init_done_out, row_strobe_n_out, upper_byte_strobe_n_out;
  logic lower_byte_strobe_n_out, write_enable_n_out, output_enable_n_out, data_oe_out;
  logic [15:0] rd_data_out, data_in, data_out, got;
  logic [8:0] address_inputs_out;
  int row_cycles, refreshes, base, n_fail = 0, num_checks = 0;
  // Free-running core clock.
  always #5 core_clk_in = ~core_clk_in;
  dram_host_ctrl #(.POWER_UP_COUNT(20)) uut (.core_clk_in, .rst_b_in, .req_valid_in,
    .req_write_in, .req_row_in, .req_col_in, .req_byte_en_in, .req_wdata_in, .req_ready_out,
    .rd_valid_out, .rd_data_out, .init_done_out, .row_strobe_n_out, .upper_byte_strobe_n_out,
    .lower_byte_strobe_n_out, .write_enable_n_out, .output_enable_n_out, .address_inputs_out,
    .data_in, .data_out, .data_oe_out);
  dram_model mem_i (.row_strobe_n_in(row_strobe_n_out), .upper_byte_strobe_n_in(upper_byte_strobe_n_out),
    .lower_byte_strobe_n_in(lower_byte_strobe_n_out), .write_enable_n_in(write_enable_n_out),
    .output_enable_n_in(output_enable_n_out), .address_in(address_inputs_out),
    .host_data_in(data_out), .host_oe_in(data_oe_out), .pins_out(data_in),
    .row_cycles_out(row_cycles), .refreshes_out(refreshes));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic timed_out(input int n, input int lim);
    if (n >= lim) begin
      n_fail++;
      test_done();
    end
  endtask
  // One request, held until taken; a read waits for its data pulse.
  task automatic xfer(input logic wr, input logic [8:0] r, input logic [8:0] c,
      input logic [1:0] be, input logic [15:0] wd, output logic [15:0] rd);
    int n = 0;
    rd = 16'h0000;
    @(posedge core_clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= wr;
    req_row_in <= r;
    req_col_in <= c;
    req_byte_en_in <= be;
    req_wdata_in <= wd;
    @(negedge core_clk_in);
    while (req_ready_out !== 1'b1 && n < 400) begin
      @(negedge core_clk_in);
      n++;
    end
    timed_out(n, 400);
    @(posedge core_clk_in);
    req_valid_in <= 1'b0;
    while (!wr && rd_valid_out !== 1'b1 && n < 400) begin
      @(negedge core_clk_in);
      n++;
    end
    timed_out(n, 400);
    rd = rd_data_out;
  endtask
  // Pause, then at least eight row cycles before requests are served.
  task automatic t_init();
    int n = 0;
    while (init_done_out !== 1'b1 && n < 2000) begin
      @(negedge core_clk_in);
      n++;
    end
    timed_out(n, 2000);
    check(16'(row_cycles >= 8), 16'h0001);
  endtask
  // Word write and read back on a fresh row.
  task automatic t_word();
    xfer(1'b1, 9'h000, 9'h000, 2'h3, 16'ha55a, got);
    xfer(1'b0, 9'h000, 9'h000, 2'h3, 16'h0000, got);
    check(got, 16'ha55a);
  endtask
  // Last row, both end columns in one page, writes and reads mixed.
  task automatic t_page();
    xfer(1'b1, 9'h1ff, 9'h1ff, 2'h3, 16'h1234, got);
    xfer(1'b1, 9'h1ff, 9'h000, 2'h3, 16'hbeef, got);
    xfer(1'b0, 9'h1ff, 9'h1ff, 2'h3, 16'h0000, got);
    check(got, 16'h1234);
    xfer(1'b0, 9'h1ff, 9'h000, 2'h3, 16'h0000, got);
    check(got, 16'hbeef);
  endtask
  // Byte writes touch only their own lane.
  task automatic t_byte();
    xfer(1'b1, 9'h1ff, 9'h1ff, 2'h2, 16'hcdef, got);
    xfer(1'b1, 9'h1ff, 9'h1ff, 2'h1, 16'h9977, got);
    xfer(1'b0, 9'h1ff, 9'h1ff, 2'h3, 16'h0000, got);
    check(got, 16'hcd77);
  endtask
  // Idle past one refresh interval; data survives the refresh.
  task automatic t_refresh();
    base = refreshes;
    repeat (3300) @(posedge core_clk_in);
    check(16'(refreshes > base), 16'h0001);
    xfer(1'b0, 9'h1ff, 9'h000, 2'h3, 16'h0000, got);
    check(got, 16'hbeef);
  endtask
  // Reset, then the scenarios in order.
  initial begin
    repeat (10) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    t_init();
    t_word();
    t_page();
    t_byte();
    t_refresh();
    test_done();
  end
endmodule // page_mode_dram_core_behaviour_test
